//--- rtl/asc_regs.svh
// Register map, field positions, reset values and timing counts of the serial channel
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define ASC_ADDR_W        12
`define ASC_OFS_DATA      12'h000
`define ASC_OFS_IEN       12'h004
`define ASC_OFS_IID       12'h008
`define ASC_OFS_LCTL      12'h00c
`define ASC_OFS_MCTL      12'h010
`define ASC_OFS_LSTAT     12'h014
`define ASC_OFS_MSTAT     12'h018
`define ASC_OFS_SCR       12'h01c
`define ASC_OFS_DIVL      12'h020
`define ASC_OFS_DIVH      12'h024

// ****************************************
// Fields
// ****************************************
`define ASC_IEN_RDA       0
`define ASC_IEN_HOLDING_EMPTY_FLAG      1
`define ASC_IEN_RLS       2
`define ASC_IEN_MS        3
`define ASC_LCTL_PEN      3
`define ASC_LCTL_EPS      4
`define ASC_IID_NONE      3'h1
`define ASC_IID_RLS       3'h6
`define ASC_IID_RDA       3'h4
`define ASC_IID_HOLDING_EMPTY_FLAG      3'h2
`define ASC_IID_MS        3'h0
`define ASC_MCTL_W        5

// ****************************************
// Reset values and timing
// ****************************************
`define ASC_IEN_RST       4'h0
`define ASC_MCTL_RST      5'h00
`define ASC_TICKS_LAST    4'hf
`define ASC_START_MID     4'h7
`define ASC_CLK_NS        10
`define ASC_RESET_NS      500
`define ASC_RESET_CYC     ((`ASC_RESET_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS)

`endif

//--- rtl/asc_pkg.sv
// Types of the serial channel
package asc_pkg;
  typedef enum logic [2:0] {ASC_IDLE, ASC_START, ASC_DATA, ASC_PAR, ASC_STOP} asc_st_t;
endpackage

//--- rtl/asc_top.sv
// Asynchronous serial channel with APB register access
`timescale 1ns/1ps
`include "asc_regs.svh"
// Summary of operation
// - Receiver takes 5 to 8 bits, first bit in bit 0, upper bits zero.
// - Receiver samples on the sixteen-times clock, phased from the start bit.
// - A complete character loads the receive buffer and sets data ready.
// - Reading the receive buffer clears data ready.
// - A new character over an unread one overwrites it and flags overrun.
// - Wrong parity flags parity error; missing stop bit flags framing error.
// - Falling edge starts a count to the start-bit centre; still low accepts it.
// - Line control picks length, parity enable and parity polarity for both directions.
// - Transmitter uses the same length, ignores upper bits, sends bit 0 first.
// - Holding write clears holding-empty; transfer at start bit sets it again.
// - Transmitter-empty is high only when holding and shift registers are empty.
// - An 8-bit scratch register stores writes and affects nothing.
// - Interrupt priority: line status, data ready, holding empty, modem status.
// - Identification bit 0 low when pending; bits 1-2 give source; 3-7 zero.
// - Codes 110, 100, 010, 000, each cleared by its own access.
// - Enable bits 0-3 enable the four sources; bits 4-7 read zero.
// - With enables off no identification and no interrupt; status still sets.
// - Baud clock divides the clock by the 16-bit divisor; one is divide-by-one.
// - Baud output is sixteen times bit rate; divisor writes reload the counter.
// - Reset clears counters, modem control and line status, sets both empty flags.
// - Reset keeps line control, divisors, receive buffer and holding register.
// - After reset, enabling holding-empty interrupts raises an interrupt.
module asc_top (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_b,
  // APB slave
  input  wire logic [`ASC_ADDR_W-1:0] i_paddr,
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [31:0]            i_pwdata,
  output logic      [31:0]            o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  // Serial line and modem
  input  wire logic                   i_serial_in,
  output logic                        o_serial_out,
  input  wire logic                   i_modem_change,
  output logic      [`ASC_MCTL_W-1:0] o_modem_control,
  // Interrupt
  output logic                        o_interrupt_output
);

  // ****************************************
  // Bus decode
  // ****************************************
  function automatic logic hit(input logic [`ASC_ADDR_W-1:0] a, input logic [`ASC_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [7:0] len_mask(input logic [1:0] len);
    len_mask = 8'hff >> (2'h3 - len);
  endfunction

  logic       acc, wr, rd, mapped;
  logic [7:0] wdat;
  assign acc       = i_psel & i_penable;
  assign wr        = acc & i_pwrite;
  assign rd        = acc & ~i_pwrite;
  assign wdat      = i_pwdata[7:0];
  assign mapped    = (i_paddr <= `ASC_OFS_DIVH) && (i_paddr[1:0] == 2'h0);
  assign o_pready  = 1'b1;
  assign o_pslverr = acc & ~mapped;

  logic wr_thr, rd_rbr, rd_iid, rd_lsr, rd_msr, wr_div;
  assign wr_thr = wr & hit(i_paddr, `ASC_OFS_DATA);
  assign rd_rbr = rd & hit(i_paddr, `ASC_OFS_DATA);
  assign rd_iid = rd & hit(i_paddr, `ASC_OFS_IID);
  assign rd_lsr = rd & hit(i_paddr, `ASC_OFS_LSTAT);
  assign rd_msr = rd & hit(i_paddr, `ASC_OFS_MSTAT);
  assign wr_div = wr & (hit(i_paddr, `ASC_OFS_DIVL) | hit(i_paddr, `ASC_OFS_DIVH));

  // ****************************************
  // Registers
  // ****************************************
  logic [3:0]             ier_q;
  logic [7:0]             lcr_q, scr_q, dll_q, dlm_q, rbr_q, thr_q;
  logic [`ASC_MCTL_W-1:0] mcr_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ier_q <= `ASC_IEN_RST;
      mcr_q <= `ASC_MCTL_RST;
    end else if (wr) begin
      if (hit(i_paddr, `ASC_OFS_IEN))  ier_q <= wdat[3:0];
      if (hit(i_paddr, `ASC_OFS_MCTL)) mcr_q <= wdat[`ASC_MCTL_W-1:0];
    end
  end

  // Deliberately outside reset so a hardware reset keeps the programmed line setup
  always_ff @(posedge i_clk) begin
    if (wr && hit(i_paddr, `ASC_OFS_LCTL)) lcr_q <= wdat;
    if (wr && hit(i_paddr, `ASC_OFS_DIVL)) dll_q <= wdat;
    if (wr && hit(i_paddr, `ASC_OFS_DIVH)) dlm_q <= wdat;
    if (wr && hit(i_paddr, `ASC_OFS_SCR))  scr_q <= wdat;
    if (wr_thr) thr_q <= wdat;
  end
  assign o_modem_control = mcr_q;

  // ****************************************
  // Baud generator
  // ****************************************
  logic [15:0] div, bcnt_q;
  logic        tick;
  assign div  = {dlm_q, dll_q};
  assign tick = (bcnt_q <= 16'h0001);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) bcnt_q <= 16'h0000;
    else if (wr_div) bcnt_q <= hit(i_paddr, `ASC_OFS_DIVL) ? {dlm_q, wdat} : {wdat, dll_q};
    else if (tick) bcnt_q <= div;
    else bcnt_q <= bcnt_q - 16'h0001;
  end

  // ****************************************
  // Transmitter
  // ****************************************
  asc_pkg::asc_st_t tx_st_q;
  logic [3:0] tx_cnt_q;
  logic [2:0] tx_bit_q;
  logic [7:0] tsr_q;
  logic       hold_full_q, tx_load, tx_last, tx_par, holding_empty_flag, transmitter_empty_flag;
  assign tx_load = (tx_st_q == asc_pkg::ASC_IDLE) & hold_full_q;
  assign tx_last = tick & (tx_cnt_q == `ASC_TICKS_LAST);
  assign tx_par  = ~lcr_q[`ASC_LCTL_EPS] ^ (^(tsr_q & len_mask(lcr_q[1:0])));
  assign holding_empty_flag    = ~hold_full_q;
  assign transmitter_empty_flag    = holding_empty_flag & (tx_st_q == asc_pkg::ASC_IDLE);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) hold_full_q <= 1'b0;
    else hold_full_q <= wr_thr | (hold_full_q & ~tx_load);
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_st_q  <= asc_pkg::ASC_IDLE;
      tx_cnt_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tsr_q    <= 8'h00;
    end else begin
      if (tick) tx_cnt_q <= tx_cnt_q + 4'h1;
      unique case (tx_st_q)
        asc_pkg::ASC_IDLE: if (tx_load) begin
          tsr_q    <= thr_q;
          tx_cnt_q <= 4'h0;
          tx_st_q  <= asc_pkg::ASC_START;
        end
        asc_pkg::ASC_START: if (tx_last) begin
          tx_bit_q <= 3'h0;
          tx_st_q  <= asc_pkg::ASC_DATA;
        end
        asc_pkg::ASC_DATA: if (tx_last) begin
          tx_bit_q <= tx_bit_q + 3'h1;
          if (tx_bit_q == {1'b1, lcr_q[1:0]})
            tx_st_q <= lcr_q[`ASC_LCTL_PEN] ? asc_pkg::ASC_PAR : asc_pkg::ASC_STOP;
        end
        asc_pkg::ASC_PAR: if (tx_last) tx_st_q <= asc_pkg::ASC_STOP;
        asc_pkg::ASC_STOP: if (tx_last) tx_st_q <= asc_pkg::ASC_IDLE;
      endcase
    end
  end

  always_comb begin
    unique case (tx_st_q)
      asc_pkg::ASC_START: o_serial_out = 1'b0;
      asc_pkg::ASC_DATA:  o_serial_out = tsr_q[tx_bit_q];
      asc_pkg::ASC_PAR:   o_serial_out = tx_par;
      default:            o_serial_out = 1'b1;
    endcase
  end

  // ****************************************
  // Receiver
  // ****************************************
  asc_pkg::asc_st_t rx_st_q;
  logic [3:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rsr_q;
  logic       rx_prev_q, rx_par_q, rx_mid, rx_ctr, rx_load;
  logic       dr_q, oe_q, pe_q, fe_q;
  // Start centre at the eighth tick, data centres every sixteen ticks after it
  assign rx_mid  = tick & (rx_cnt_q == `ASC_START_MID);
  assign rx_ctr  = tick & (rx_cnt_q == `ASC_TICKS_LAST);
  assign rx_load = (rx_st_q == asc_pkg::ASC_STOP) & rx_ctr;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_st_q   <= asc_pkg::ASC_IDLE;
      rx_cnt_q  <= 4'h0;
      rx_bit_q  <= 3'h0;
      rsr_q     <= 8'h00;
      rx_prev_q <= 1'b1;
      rx_par_q  <= 1'b0;
    end else begin
      rx_prev_q <= i_serial_in;
      if (tick) rx_cnt_q <= rx_cnt_q + 4'h1;
      unique case (rx_st_q)
        asc_pkg::ASC_IDLE: if (rx_prev_q && !i_serial_in) begin
          rx_cnt_q <= 4'h0;
          rx_st_q  <= asc_pkg::ASC_START;
        end
        asc_pkg::ASC_START: if (rx_mid) begin
          rx_cnt_q <= 4'h0;
          rx_bit_q <= 3'h0;
          rsr_q    <= 8'h00;
          rx_st_q  <= i_serial_in ? asc_pkg::ASC_IDLE : asc_pkg::ASC_DATA;
        end
        asc_pkg::ASC_DATA: if (rx_ctr) begin
          rsr_q[rx_bit_q] <= i_serial_in;
          rx_bit_q <= rx_bit_q + 3'h1;
          if (rx_bit_q == {1'b1, lcr_q[1:0]})
            rx_st_q <= lcr_q[`ASC_LCTL_PEN] ? asc_pkg::ASC_PAR : asc_pkg::ASC_STOP;
        end
        asc_pkg::ASC_PAR: if (rx_ctr) begin
          rx_par_q <= i_serial_in;
          rx_st_q  <= asc_pkg::ASC_STOP;
        end
        asc_pkg::ASC_STOP: if (rx_ctr) rx_st_q <= asc_pkg::ASC_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (rx_load) rbr_q <= rsr_q & len_mask(lcr_q[1:0]);
  end

  // Set beats clear when an event meets the clearing read
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dr_q <= 1'b0;
      oe_q <= 1'b0;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
    end else begin
      dr_q <= rx_load | (dr_q & ~rd_rbr);
      oe_q <= (rx_load & dr_q & ~rd_rbr) | (oe_q & ~rd_lsr);
      pe_q <= (rx_load & lcr_q[`ASC_LCTL_PEN] &
               (rx_par_q != (~lcr_q[`ASC_LCTL_EPS] ^ (^(rsr_q & len_mask(lcr_q[1:0])))))) |
              (pe_q & ~rd_lsr);
      fe_q <= (rx_load & ~i_serial_in) | (fe_q & ~rd_lsr);
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  logic       holding_empty_flag_pend_q, holding_empty_flag_prev_q, msr_d_q, p_rls, p_rda, p_holding_empty_flag, p_ms;
  logic [7:0] iid;
  assign p_rls  = ier_q[`ASC_IEN_RLS]  & (oe_q | pe_q | fe_q);
  assign p_rda  = ier_q[`ASC_IEN_RDA]  & dr_q;
  assign p_holding_empty_flag = ier_q[`ASC_IEN_HOLDING_EMPTY_FLAG] & holding_empty_flag_pend_q;
  assign p_ms   = ier_q[`ASC_IEN_MS]   & msr_d_q;

  always_comb begin
    if (p_rls)       iid = {5'h00, `ASC_IID_RLS};
    else if (p_rda)  iid = {5'h00, `ASC_IID_RDA};
    else if (p_holding_empty_flag) iid = {5'h00, `ASC_IID_HOLDING_EMPTY_FLAG};
    else if (p_ms)   iid = {5'h00, `ASC_IID_MS};
    else             iid = {5'h00, `ASC_IID_NONE};
  end
  assign o_interrupt_output = ~iid[0];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      holding_empty_flag_pend_q <= 1'b1;
      holding_empty_flag_prev_q <= 1'b1;
      msr_d_q     <= 1'b0;
    end else begin
      holding_empty_flag_prev_q <= holding_empty_flag;
      holding_empty_flag_pend_q <= (holding_empty_flag & ~holding_empty_flag_prev_q) |
                     (holding_empty_flag_pend_q & ~wr_thr & ~(rd_iid & (iid[2:0] == `ASC_IID_HOLDING_EMPTY_FLAG)));
      msr_d_q     <= i_modem_change | (msr_d_q & ~rd_msr);
    end
  end

  // ****************************************
  // Read data, captured in the setup phase so the bus sees a flop
  // ****************************************
  logic [7:0] rmux;
  always_comb begin
    unique case (i_paddr)
      `ASC_OFS_DATA:  rmux = rbr_q;
      `ASC_OFS_IEN:   rmux = {4'h0, ier_q};
      `ASC_OFS_IID:   rmux = iid;
      `ASC_OFS_LCTL:  rmux = lcr_q;
      `ASC_OFS_MCTL:  rmux = {3'h0, mcr_q};
      `ASC_OFS_LSTAT: rmux = {1'b0, transmitter_empty_flag, holding_empty_flag, 1'b0, fe_q, pe_q, oe_q, dr_q};
      `ASC_OFS_MSTAT: rmux = {7'h00, msr_d_q};
      `ASC_OFS_SCR:   rmux = scr_q;
      `ASC_OFS_DIVL:  rmux = dll_q;
      `ASC_OFS_DIVH:  rmux = dlm_q;
      default:        rmux = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) o_prdata <= 32'h0000_0000;
    else if (i_psel && !i_penable) o_prdata <= {24'h00_0000, rmux};
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_dr_clear:    assert property (rd_rbr && !rx_load |=> !dr_q) else $error("data ready not cleared");
  a_dr_set:      assert property (rx_load |=> dr_q && rbr_q == $past(rsr_q & len_mask(lcr_q[1:0])))
                   else $error("buffer not loaded");
  a_overrun:     assert property (rx_load && dr_q && !rd_rbr |=> oe_q) else $error("overrun missed");
  a_holding_empty_flag_clear:  assert property (wr_thr |=> !holding_empty_flag ##0 !transmitter_empty_flag) else $error("holding empty not cleared");
  a_holding_empty_flag_load:   assert property (tx_load && !wr_thr |=> holding_empty_flag && tx_st_q == asc_pkg::ASC_START)
                   else $error("holding not moved at start bit");
  a_fe_set:      assert property (rx_load && !i_serial_in |=> fe_q) else $error("framing error missed");
  a_transmitter_empty_flag_busy:   assert property (tx_st_q != asc_pkg::ASC_IDLE |-> !transmitter_empty_flag) else $error("empty while shifting");
  a_idle_mark:   assert property (tx_st_q == asc_pkg::ASC_IDLE |-> o_serial_out) else $error("idle line low");
  a_start_len:   assert property ($rose(tx_st_q == asc_pkg::ASC_START) && div == 16'h0001 && !wr_div
                   |-> (!o_serial_out)[*8] ##1 (!o_serial_out)[*8]) else $error("start bit length");
  a_iid_form:    assert property (iid[7:3] == 5'h00 && iid[0] == !(p_rls | p_rda | p_holding_empty_flag | p_ms))
                   else $error("identification format");
  a_prio_rls:    assert property (p_rls |-> iid[2:0] == `ASC_IID_RLS) else $error("line status not first");
  a_irq_off:     assert property (ier_q == 4'h0 |-> !o_interrupt_output) else $error("interrupt while disabled");
  a_div_reload:  assert property (wr_div && hit(i_paddr, `ASC_OFS_DIVL) |=> bcnt_q == {dlm_q, dll_q})
                   else $error("baud counter not reloaded");
  a_start_false: assert property (rx_st_q == asc_pkg::ASC_START && rx_mid && i_serial_in
                   |=> rx_st_q == asc_pkg::ASC_IDLE) else $error("false start accepted");

  c_rx_char:  cover property (rx_load);
  c_overrun:  cover property (rx_load && dr_q);
  c_tx_back:  cover property (tx_load ##[1:300] wr_thr);
  c_holding_empty_flag_irq: cover property (iid[2:0] == `ASC_IID_HOLDING_EMPTY_FLAG);
  c_tx_par:   cover property (tx_st_q == asc_pkg::ASC_PAR);

endmodule

//--- sim/asc_peer.sv
// Remote serial device model facing the channel's serial line
`timescale 1ns/1ps
module asc_peer (
  // Clock and line
  input  wire logic i_clk,
  input  wire logic i_line,
  output logic      o_line
);
  int         bit_clks = 16;
  int         rx_n     = 8;
  int         rx_cnt   = 0;
  logic [7:0] got;
  logic       got_stop;
  initial o_line = 1'b1;
  // ****************************************
  // Sender; parity and stop faults only on request
  // ****************************************
  task automatic send(input logic [7:0] d, input int n, input bit pen, input bit even,
                      input bit bad_par, input bit bad_stop);
    logic [9:0] fr;
    int         k;
    fr = '0;
    for (int i = 0; i < n; i++) fr[i] = d[i];
    k = n;
    if (pen) begin
      fr[k] = (^fr) ^ ~even ^ bad_par;
      k++;
    end
    fr[k] = ~bad_stop;
    @(posedge i_clk);
    o_line <= 1'b0;
    repeat (bit_clks) @(posedge i_clk);
    for (int i = 0; i <= k; i++) begin
      o_line <= fr[i];
      repeat (bit_clks) @(posedge i_clk);
    end
    o_line <= 1'b1;
    repeat (bit_clks) @(posedge i_clk);
  endtask
  // Short low spike, too brief to be a start bit
  task automatic glitch();
    @(posedge i_clk);
    o_line <= 1'b0;
    repeat (3) @(posedge i_clk);
    o_line <= 1'b1;
  endtask
  // ****************************************
  // Receiver, samples at bit centres
  // ****************************************
  initial forever begin
    @(negedge i_line);
    repeat (bit_clks / 2) @(posedge i_clk);
    got = '0;
    for (int i = 0; i < rx_n; i++) begin
      repeat (bit_clks) @(posedge i_clk);
      got[i] = i_line;
    end
    repeat (bit_clks) @(posedge i_clk);
    got_stop = i_line;
    rx_cnt++;
  end
endmodule

//--- sim/asc_top_tb.sv
// Self-checking testbench of the serial channel
`timescale 1ns/1ps
`include "asc_regs.svh"
module asc_top_tb;
  logic        i_clk   = 1'b0;
  logic        i_rst_b = 1'b0;
  logic [11:0] i_paddr = '0;
  logic        i_psel  = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite  = 1'b0;
  logic [31:0] i_pwdata  = '0;
  logic        i_modem_change = 1'b0;
  logic        ser_in;
  logic        ser_out;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic        o_irq;
  logic [4:0]  mctl_pin;
  logic [31:0] rdv;
  logic        err;
  int          bad_count = 0;
  int          cmp_count = 0;
  always #5 i_clk = ~i_clk;
  asc_top asc_top_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_paddr(i_paddr), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_serial_in(ser_in), .o_serial_out(ser_out),
    .i_modem_change(i_modem_change), .o_modem_control(mctl_pin), .o_interrupt_output(o_irq));
  asc_peer asc_peer_inst (.i_clk(i_clk), .i_line(ser_out), .o_line(ser_in));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_psel   <= 1'b1;
    i_pwrite <= wr;
    i_paddr  <= a;
    i_pwdata <= {24'h0, d};
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rdv = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, rdv, {24'h0, e});
  endtask
  // Bounded wait for the peer to collect a frame, then compare it
  task automatic tx_got(input int n, input logic [7:0] e);
    int t;
    t = 0;
    while (asc_peer_inst.rx_cnt < n && t < 4000) begin
      @(posedge i_clk);
      t++;
    end
    chk("frames", asc_peer_inst.rx_cnt, n);
    chk("tx_data", {24'h0, asc_peer_inst.got}, {24'h0, e});
    chk("tx_stop", {31'h0, asc_peer_inst.got_stop}, 32'h1);
  endtask
  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (40000) @(posedge i_clk);
    bad_count++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd("lstat", `ASC_OFS_LSTAT, 8'h60);
    rd("iid", `ASC_OFS_IID, 8'h01);
    rd("mctl", `ASC_OFS_MCTL, 8'h00);
    rd("unmapped", 12'h040, 8'h00);
    chk("slverr", {31'h0, err}, 32'h1);
    // High latch first, so the low-latch reload never takes an unwritten byte
    wr(`ASC_OFS_DIVH, 8'h00);
    wr(`ASC_OFS_DIVL, 8'h01);
    wr(`ASC_OFS_LCTL, 8'h03);
    wr(`ASC_OFS_SCR, 8'ha5);
    rd("scratch", `ASC_OFS_SCR, 8'ha5);
    // Enables written last, as software should
    wr(`ASC_OFS_IEN, 8'h02);
    rd("iid", `ASC_OFS_IID, 8'h02);
    chk("irq", {31'h0, o_irq}, 32'h1);
    rd("iid", `ASC_OFS_IID, 8'h01);
    chk("irq", {31'h0, o_irq}, 32'h0);
    wr(`ASC_OFS_IEN, 8'h00);
    wr(`ASC_OFS_DATA, 8'h4b);
    rd("lstat", `ASC_OFS_LSTAT, 8'h20);
    wr(`ASC_OFS_DATA, 8'h96);
    rd("lstat", `ASC_OFS_LSTAT, 8'h00);
    tx_got(1, 8'h4b);
    tx_got(2, 8'h96);
    repeat (24) @(posedge i_clk);
    rd("lstat", `ASC_OFS_LSTAT, 8'h60);
    wr(`ASC_OFS_LCTL, 8'h00);
    asc_peer_inst.rx_n = 5;
    wr(`ASC_OFS_DATA, 8'hff);
    tx_got(3, 8'h1f);
    repeat (16) @(posedge i_clk);
    wr(`ASC_OFS_LCTL, 8'h18);
    asc_peer_inst.rx_n = 6;
    wr(`ASC_OFS_DATA, 8'h13);
    tx_got(4, 8'h33);
    asc_peer_inst.send(8'h13, 5, 1, 1, 0, 0);
    rd("lstat", `ASC_OFS_LSTAT, 8'h61);
    rd("rbuf", `ASC_OFS_DATA, 8'h13);
    rd("lstat", `ASC_OFS_LSTAT, 8'h60);
    wr(`ASC_OFS_LCTL, 8'h08);
    asc_peer_inst.send(8'h13, 5, 1, 0, 1, 0);
    rd("lstat", `ASC_OFS_LSTAT, 8'h65);
    rd("rbuf", `ASC_OFS_DATA, 8'h13);
    wr(`ASC_OFS_LCTL, 8'h03);
    asc_peer_inst.send(8'h5a, 8, 0, 0, 0, 1);
    rd("lstat", `ASC_OFS_LSTAT, 8'h69);
    rd("rbuf", `ASC_OFS_DATA, 8'h5a);
    wr(`ASC_OFS_IEN, 8'h07);
    asc_peer_inst.send(8'ha1, 8, 0, 0, 0, 0);
    asc_peer_inst.send(8'ha2, 8, 0, 0, 0, 0);
    rd("iid", `ASC_OFS_IID, 8'h06);
    rd("lstat", `ASC_OFS_LSTAT, 8'h63);
    rd("iid", `ASC_OFS_IID, 8'h04);
    rd("rbuf", `ASC_OFS_DATA, 8'ha2);
    rd("iid", `ASC_OFS_IID, 8'h02);
    rd("iid", `ASC_OFS_IID, 8'h01);
    wr(`ASC_OFS_IEN, 8'h08);
    @(posedge i_clk);
    i_modem_change <= 1'b1;
    @(posedge i_clk);
    i_modem_change <= 1'b0;
    rd("iid", `ASC_OFS_IID, 8'h00);
    rd("mstat", `ASC_OFS_MSTAT, 8'h01);
    rd("iid", `ASC_OFS_IID, 8'h01);
    asc_peer_inst.glitch();
    repeat (400) @(posedge i_clk);
    rd("lstat", `ASC_OFS_LSTAT, 8'h60);
    // Slower rate checks the divisor reload
    wr(`ASC_OFS_DIVL, 8'h02);
    asc_peer_inst.bit_clks = 32;
    asc_peer_inst.rx_n = 8;
    asc_peer_inst.send(8'hc3, 8, 0, 0, 0, 0);
    rd("rbuf", `ASC_OFS_DATA, 8'hc3);
    wr(`ASC_OFS_DATA, 8'h3c);
    tx_got(5, 8'h3c);
    wr(`ASC_OFS_MCTL, 8'h1f);
    // Mid-run reset held the full minimum time
    @(posedge i_clk);
    chk("mctl_pin", {27'h0, mctl_pin}, 32'h1f);
    i_rst_b <= 1'b0;
    repeat (50) @(posedge i_clk);
    i_rst_b <= 1'b1;
    chk("mctl_pin", {27'h0, mctl_pin}, 32'h0);
    rd("lctl", `ASC_OFS_LCTL, 8'h03);
    rd("lstat", `ASC_OFS_LSTAT, 8'h60);
    rd("mctl", `ASC_OFS_MCTL, 8'h00);
    rd("iid", `ASC_OFS_IID, 8'h01);
    rd("rbuf", `ASC_OFS_DATA, 8'hc3);
    asc_peer_inst.send(8'h77, 8, 0, 0, 0, 0);
    rd("rbuf", `ASC_OFS_DATA, 8'h77);
    test_done();
  end
endmodule
